// >>> rtl/rxsdo_pkg.sv
// package for the receive system data output stage
package rxsdo_pkg;

   // ==========================================================
   // sizes
   localparam int LINKS = 8;
   localparam int GROUP = 4;

   // ==========================================================
   // register map (byte addresses, one word each)
   localparam logic [11:0] RXSDO_GLOBAL_ADDR  = 12'h040; // 010H word
   localparam logic [11:0] RXSDO_DRVDIS_ADDR  = 12'h08C; // 023H word
   localparam logic [11:0] RXSDO_STATUS_ADDR  = 12'h100;
   localparam logic [11:0] RXSDO_SIGPOS_ADDR  = 12'h104;

   // field positions
   localparam int SLAVE_SEL_BIT = 4;  // link-1 clock select
   localparam int MODE_LSB      = 0;  // two-bit output mode
   localparam int DRV_DIS_BIT   = 4;  // per-link driver disable

   // reset values
   localparam logic [31:0] GLOBAL_RST = 32'h0000_0000;
   localparam logic [7:0]  DRVDIS_RST = 8'h00;
   localparam logic [7:0]  SIG_MASK   = 8'h0F;  // lower nibble b5..b8

   // ==========================================================
   // types
   typedef enum logic [1:0] {
      RXSDO_MASTER = 2'b00,
      RXSDO_SLAVE  = 2'b01,
      RXSDO_MUX    = 2'b10
   } rxsdo_mode_t;

   typedef struct packed {
      logic [7:0] data;
      logic [7:0] sig;
   } rxsdo_byte_t;

endpackage : rxsdo_pkg

// >>> rtl/rxsdo_buf.sv
// two-entry valid/ready buffer for one data byte word
`timescale 1ns/1ns
`default_nettype none
module rxsdo_buf
   import rxsdo_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // fill side
   input  wire logic        in_valid,
   output logic             in_ready,
   input  wire rxsdo_byte_t in_data,
   // drain side
   output logic             out_valid,
   input  wire logic        out_ready,
   output rxsdo_byte_t      out_data
);

   // ==========================================================
   // storage
   rxsdo_byte_t mem_reg [2];
   logic        wptr_reg;
   logic        rptr_reg;
   logic [1:0]  count_reg;
   logic        push;
   logic        pop;

   // full only at two, so a stalled drain really back-pressures
   assign in_ready  = (count_reg != 2'd2);
   assign out_valid = (count_reg != 2'd0);
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   assign out_data  = mem_reg[rptr_reg];

   // write side
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wptr_reg <= 1'b0;
         mem_reg[0] <= '0;
         mem_reg[1] <= '0;
      end else if (push) begin
         mem_reg[wptr_reg] <= in_data;
         wptr_reg <= ~wptr_reg;
      end
   end

   // read side and occupancy
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rptr_reg  <= 1'b0;
         count_reg <= 2'd0;
      end else begin
         if (pop) begin
            rptr_reg <= ~rptr_reg;
         end
         count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
      end
   end

endmodule : rxsdo_buf
`default_nettype wire

// >>> rtl/rxsdo_top.sv
// receive system data output stage: serial, slave and multiplexed outputs
//
// Functional notes
// R1: global disable pin high tri-states line drivers of all eight links.
// R2: per-link disable bit 4 at 023H tri-states only that link's drivers.
// R3: master mode updates each serial output on its own link clock.
// R4: slave mode, bit 4 at 010H picks own clock or link-1 clock.
// R5: multiplexed mode byte-interleaves links 1-4 and links 5-8 onto two outputs.
// R6: both multiplexed outputs update on the common multiplexed clock.
// R7: backup multiplexed outputs carry exactly the primary outputs' data.
// R8: signaling sits in lower nibble, aligned with its channel's data.
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module rxsdo_top
   import rxsdo_pkg::*;
(
   // clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // apb slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [11:0]        paddr,
   input  wire logic [31:0]        pwdata,
   output logic [31:0]             prdata,
   output logic                    pready,
   output logic                    pslverr,
   // framer byte stream, one byte per link at a time
   input  wire logic [LINKS-1:0]   byte_valid,
   output logic [LINKS-1:0]        byte_ready,
   input  wire rxsdo_byte_t [LINKS-1:0] byte_in,
   // timing strobes sampled on pclk
   input  wire logic [LINKS-1:0]   rx_sys_clock,
   input  wire logic               rx_mux_clock,
   // serial system outputs
   output logic [LINKS-1:0]        rx_sys_serial_out,
   output logic [LINKS-1:0]        rx_signaling_out,
   // multiplexed system outputs
   output logic [1:0]              rx_mux_out_primary,
   output logic [1:0]              rx_mux_out_backup,
   output logic [1:0]              rx_mux_sig_primary,
   output logic [1:0]              rx_mux_sig_backup,
   // line driver control
   input  wire logic               global_driver_disable_in,
   input  wire logic [LINKS-1:0]   line_out_positive_in,
   input  wire logic [LINKS-1:0]   line_out_negative_in,
   output logic [LINKS-1:0]        line_out_positive,
   output logic [LINKS-1:0]        line_out_negative,
   output logic [LINKS-1:0]        line_out_oe
);

   // ==========================================================
   // registers
   logic [31:0]       global_reg;
   logic [LINKS-1:0]  link_driver_disable_bit;
   logic [31:0]       prdata_next;
   rxsdo_mode_t       mode;
   logic              rx_slave_clock_select;
   logic              wr_en;

   assign mode = rxsdo_mode_t'(global_reg[MODE_LSB +: 2]);
   assign rx_slave_clock_select = global_reg[SLAVE_SEL_BIT];
   assign wr_en = psel & penable & pwrite;
   assign pready  = 1'b1;  // zero-wait slave
   assign pslverr = 1'b0;

   // per-link disable window, shared by write and read decode
   function automatic logic drvdis_hit(input logic [11:0] a);
      return (a >= RXSDO_DRVDIS_ADDR) &&
             (a < RXSDO_DRVDIS_ADDR + 12'h020);
   endfunction : drvdis_hit

   // link index of a disable word; first word sits at index 3
   function automatic logic [2:0] drvdis_link(input logic [11:0] a);
      return a[4:2] - 3'd3;
   endfunction : drvdis_link

   // global mode and clock select word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         global_reg <= GLOBAL_RST;
      end else if (wr_en && paddr == RXSDO_GLOBAL_ADDR) begin
         global_reg <= pwdata;
      end
   end

   // per-link driver disable; only bit 4 of each word stored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link_driver_disable_bit <= DRVDIS_RST;
      end else if (wr_en && drvdis_hit(paddr)) begin
         link_driver_disable_bit[drvdis_link(paddr)] <= pwdata[DRV_DIS_BIT];
      end
   end

   // read mux; unmapped reads return zero
   always_comb begin
      prdata_next = 32'h0000_0000;
      if (paddr == RXSDO_GLOBAL_ADDR) begin
         prdata_next = global_reg;
      end else if (drvdis_hit(paddr)) begin
         prdata_next[DRV_DIS_BIT] =
            link_driver_disable_bit[drvdis_link(paddr)];
      end else if (paddr == RXSDO_STATUS_ADDR) begin
         prdata_next = {16'h0000, byte_ready, line_out_oe};
      end else if (paddr == RXSDO_SIGPOS_ADDR) begin
         prdata_next = {24'h000000, SIG_MASK};
      end
   end

   // read data captured in setup, so it stands through the access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (psel && !penable) begin
         prdata <= prdata_next;
      end
   end

   // ==========================================================
   // line drivers
   // R1 global pin wins
   // R2 per-link bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_out_oe       <= '0;
         line_out_positive <= '0;
         line_out_negative <= '0;
      end else begin
         line_out_oe <= global_driver_disable_in ? '0
                        : ~link_driver_disable_bit;
         line_out_positive <= line_out_positive_in;
         line_out_negative <= line_out_negative_in;
      end
   end

   // ==========================================================
   // per-link clock edge selection and buffers
   logic [LINKS-1:0] clk_d_reg;
   logic             mux_d_reg;
   logic [LINKS-1:0] edge_sel;
   logic             mux_edge;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_d_reg <= '0;
         mux_d_reg <= 1'b0;
      end else begin
         clk_d_reg <= rx_sys_clock;
         mux_d_reg <= rx_mux_clock;
      end
   end
   // R6 common multiplexed clock edge
   assign mux_edge = rx_mux_clock & ~mux_d_reg;

   rxsdo_byte_t [LINKS-1:0] buf_data;
   logic [LINKS-1:0]        buf_valid;
   logic [LINKS-1:0]        buf_take;
   rxsdo_byte_t             shift_reg [LINKS];
   logic [2:0]              bit_cnt_reg [LINKS];

   genvar g;
   generate
      for (g = 0; g < LINKS; g++) begin : g_link
         // R3 own clock in master mode
         // R4 slave mode picks own or link-1 clock
         assign edge_sel[g] =
            (mode == RXSDO_SLAVE && rx_slave_clock_select)
            ? (rx_sys_clock[0] & ~clk_d_reg[0])
            : (rx_sys_clock[g] & ~clk_d_reg[g]);

         rxsdo_buf u_buf (
            .pclk      (pclk),
            .presetn   (presetn),
            .in_valid  (byte_valid[g]),
            .in_ready  (byte_ready[g]),
            .in_data   (byte_in[g]),
            .out_valid (buf_valid[g]),
            .out_ready (buf_take[g]),
            .out_data  (buf_data[g])
         );

         // serial shifter: loads a byte every eighth edge, msb first
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               shift_reg[g]   <= '0;
               bit_cnt_reg[g] <= 3'd0;
            end else if (mode != RXSDO_MUX && edge_sel[g]) begin
               bit_cnt_reg[g] <= bit_cnt_reg[g] + 3'd1;
               if (bit_cnt_reg[g] == 3'd0) begin
                  shift_reg[g] <= buf_valid[g] ? buf_data[g] : '0;
               end else begin
                  shift_reg[g].data <= {shift_reg[g].data[6:0], 1'b0};
                  shift_reg[g].sig  <= {shift_reg[g].sig[6:0], 1'b0};
               end
            end
         end
      end
   endgenerate

   // ==========================================================
   // multiplexed path: byte-interleaved groups of four links
   logic [1:0]  mux_link_reg;   // link within group
   logic [2:0]  mux_bit_reg;
   rxsdo_byte_t mux_sh_reg [2];

   always_comb begin
      buf_take = '0;
      for (int l = 0; l < LINKS; l++) begin
         if (mode == RXSDO_MUX) begin
            buf_take[l] = mux_edge && mux_bit_reg == 3'd0 &&
                          mux_link_reg == 2'(l % GROUP);
         end else begin
            buf_take[l] = edge_sel[l] && bit_cnt_reg[l] == 3'd0;
         end
      end
   end

   // R5 group a takes links 1-4, group b links 5-8
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mux_link_reg  <= 2'd0;
         mux_bit_reg   <= 3'd0;
         mux_sh_reg[0] <= '0;
         mux_sh_reg[1] <= '0;
      end else if (mode == RXSDO_MUX && mux_edge) begin
         mux_bit_reg <= mux_bit_reg + 3'd1;
         for (int k = 0; k < 2; k++) begin
            if (mux_bit_reg == 3'd0) begin
               mux_sh_reg[k] <=
                  buf_valid[k*GROUP + int'(mux_link_reg)]
                  ? buf_data[k*GROUP + int'(mux_link_reg)] : '0;
            end else begin
               mux_sh_reg[k].data <= {mux_sh_reg[k].data[6:0], 1'b0};
               mux_sh_reg[k].sig  <= {mux_sh_reg[k].sig[6:0], 1'b0};
            end
         end
         if (mux_bit_reg == 3'd7) begin
            mux_link_reg <= mux_link_reg + 2'd1;
         end
      end
   end

   // ==========================================================
   // output pins
   // R8 upper nibble masked, lower nibble shifted with its data byte
   always_comb begin
      for (int l = 0; l < LINKS; l++) begin
         rx_sys_serial_out[l] = shift_reg[l].data[7];
         rx_signaling_out[l]  = shift_reg[l].sig[7] &
                                (bit_cnt_reg[l] > 3'd4 ||
                                 bit_cnt_reg[l] == 3'd0);
      end
      for (int k = 0; k < 2; k++) begin
         rx_mux_out_primary[k] = mux_sh_reg[k].data[7];
         rx_mux_sig_primary[k] = mux_sh_reg[k].sig[7] &
                                 (mux_bit_reg > 3'd4 ||
                                  mux_bit_reg == 3'd0);
      end
   end
   // R7 backup mirrors primary
   assign rx_mux_out_backup = rx_mux_out_primary;
   assign rx_mux_sig_backup = rx_mux_sig_primary;

endmodule : rxsdo_top
`default_nettype wire

// >>> tb/rxsdo_chk.sv
// assertion checker for the receive output stage
`timescale 1ns/1ns
`default_nettype none
module rxsdo_chk
   import rxsdo_pkg::*;
(
   // clock and reset
   input wire logic             pclk,
   input wire logic             presetn,
   // strobes and driver inputs
   input wire logic [LINKS-1:0] rx_sys_clock,
   input wire logic             rx_mux_clock,
   input wire logic             global_driver_disable_in,
   input wire logic [LINKS-1:0] line_out_positive_in,
   // watched outputs
   input wire logic [LINKS-1:0] rx_sys_serial_out,
   input wire logic [LINKS-1:0] rx_signaling_out,
   input wire logic [1:0]       rx_mux_out_primary,
   input wire logic [1:0]       rx_mux_out_backup,
   input wire logic [1:0]       rx_mux_sig_primary,
   input wire logic [1:0]       rx_mux_sig_backup,
   input wire logic [LINKS-1:0] line_out_positive,
   input wire logic [LINKS-1:0] line_out_oe
);
   // ==========================================
   // strobe edges, with slack for a sync stage
   logic [LINKS:0]   stb_d;
   logic [LINKS:0]   rise;
   logic [LINKS:0]   win;
   logic [26:0]      hist;
   logic [LINKS-1:0] ok;
   assign rise = {rx_mux_clock, rx_sys_clock} & ~stb_d;
   assign win  = rise | hist[8:0] | hist[17:9] | hist[26:18];
   // link-1 strobe may time every link
   assign ok   = win[LINKS-1:0] | {LINKS{win[0]}};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stb_d <= '0;
         hist  <= '0;
      end else begin
         stb_d <= {rx_mux_clock, rx_sys_clock};
         hist  <= {hist[17:0], rise};
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========================================
   // assertions
   AST_ALL_OFF: assert property (
      global_driver_disable_in |=> line_out_oe == '0)
      else $error("drivers on under global disable");
   AST_LINE_COPY: assert property (
      $past(presetn) |-> line_out_positive == $past(line_out_positive_in))
      else $error("line data not a one-cycle copy");
   AST_SER_EDGE: assert property (
      ((rx_sys_serial_out ^ $past(rx_sys_serial_out)) & ~ok) == '0)
      else $error("serial data moved without strobe");
   AST_SIG_EDGE: assert property (
      ((rx_signaling_out ^ $past(rx_signaling_out)) & ~ok) == '0)
      else $error("signaling moved without strobe");
   AST_MUX_EDGE: assert property (
      rx_mux_out_primary != $past(rx_mux_out_primary) |-> win[LINKS])
      else $error("mux data moved without mux strobe");
   AST_MUXSIG_EDGE: assert property (
      rx_mux_sig_primary != $past(rx_mux_sig_primary) |-> win[LINKS])
      else $error("mux signaling moved without strobe");
   AST_BACKUP_DAT: assert property (
      rx_mux_out_backup == rx_mux_out_primary)
      else $error("backup mux data differs");
   AST_BACKUP_SIG: assert property (
      rx_mux_sig_backup == rx_mux_sig_primary)
      else $error("backup mux signaling differs");
   // main scenarios
   cover property (global_driver_disable_in ##1 line_out_oe == '0);
   cover property (rise[LINKS] ##1 rx_mux_out_primary != 2'h0);
   cover property (rise[0] ##1 rx_sys_serial_out[1]);
endmodule : rxsdo_chk
bind rxsdo_top rxsdo_chk chk (.pclk, .presetn, .rx_sys_clock,
   .rx_mux_clock, .global_driver_disable_in, .line_out_positive_in,
   .rx_sys_serial_out, .rx_signaling_out, .rx_mux_out_primary,
   .rx_mux_out_backup, .rx_mux_sig_primary, .rx_mux_sig_backup,
   .line_out_positive, .line_out_oe);
`default_nettype wire

// >>> tb/rxsdo_sink.sv
// backplane receiver model: samples one serial pin pair
`timescale 1ns/1ns
`default_nettype none
module rxsdo_sink (
   // clock and clear
   input  wire logic  pclk,
   input  wire logic  clr,
   // sampled lines
   input  wire logic  stb,
   input  wire logic  dat,
   input  wire logic  sig,
   // captured streams, newest bit at lsb
   output logic [63:0] dat_sr,
   output logic [63:0] sig_sr
);
   logic stb_d;
   // sample mid-bit
   // the falling strobe is far from the update edge, so no race
   always_ff @(posedge pclk) begin
      stb_d <= stb;
      if (clr) begin
         dat_sr <= '0;
         sig_sr <= '0;
      end else if (stb_d && !stb) begin
         dat_sr <= {dat_sr[62:0], dat};
         sig_sr <= {sig_sr[62:0], sig};
      end
   end
endmodule : rxsdo_sink
`default_nettype wire

// >>> tb/rxsdo_bench.sv
// self-checking bench for the receive output stage
`timescale 1ns/1ns
`default_nettype none
module rxsdo_bench;
   import rxsdo_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic rx_mux_clock, global_driver_disable_in, clr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [LINKS-1:0] byte_valid, byte_ready, rx_sys_clock, line_out_oe;
   logic [LINKS-1:0] rx_sys_serial_out, rx_signaling_out;
   logic [LINKS-1:0] line_out_positive_in, line_out_negative_in;
   logic [LINKS-1:0] line_out_positive, line_out_negative;
   logic [1:0] rx_mux_out_primary, rx_mux_out_backup;
   logic [1:0] rx_mux_sig_primary, rx_mux_sig_backup;
   logic [2:0] si, sc;
   logic [63:0] sd, ss, m0, m1, u0, u1, b1, v1;
   rxsdo_byte_t [LINKS-1:0] byte_in;
   int n_mismatch, n_tests;
   rxsdo_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .byte_valid, .byte_ready,
      .byte_in, .rx_sys_clock, .rx_mux_clock, .rx_sys_serial_out,
      .rx_signaling_out, .rx_mux_out_primary, .rx_mux_out_backup,
      .rx_mux_sig_primary, .rx_mux_sig_backup,
      .global_driver_disable_in, .line_out_positive_in,
      .line_out_negative_in, .line_out_positive, .line_out_negative,
      .line_out_oe);
   rxsdo_sink s_ser (.pclk, .clr, .stb(rx_sys_clock[sc]),
      .dat(rx_sys_serial_out[si]), .sig(rx_signaling_out[si]),
      .dat_sr(sd), .sig_sr(ss));
   rxsdo_sink s_m0 (.pclk, .clr, .stb(rx_mux_clock),
      .dat(rx_mux_out_primary[0]), .sig(rx_mux_sig_primary[0]),
      .dat_sr(m0), .sig_sr(u0));
   rxsdo_sink s_m1 (.pclk, .clr, .stb(rx_mux_clock),
      .dat(rx_mux_out_primary[1]), .sig(rx_mux_sig_primary[1]),
      .dat_sr(m1), .sig_sr(u1));
   rxsdo_sink s_b1 (.pclk, .clr, .stb(rx_mux_clock),
      .dat(rx_mux_out_backup[1]), .sig(rx_mux_sig_backup[1]),
      .dat_sr(b1), .sig_sr(v1));
   // ==========================================
   // shared tasks
   initial pclk = 0;
   always #50 pclk = ~pclk;
   task automatic chk(input string w, input logic [31:0] e, g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", w, e, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      // only the watchdog ends a wait for the answer
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      chk("pslverr", 1'b0, pslverr);
      psel <= 0;
      penable <= 0;
      // idle edge so a following call never re-raises psel at once
      @(posedge pclk);
   endtask : apb
   task automatic put(input int l, input logic [15:0] b);
      byte_in[l] <= b;
      byte_valid[l] <= 1;
      do begin
         @(posedge pclk);
      end while (byte_ready[l] !== 1'b1);
      byte_valid[l] <= 0;
      @(posedge pclk);
   endtask : put
   // strobe high two cycles, low two cycles
   task automatic pulse(input logic [LINKS:0] m, input int n);
      repeat (n) begin
         {rx_mux_clock, rx_sys_clock} <= m;
         repeat (2) @(posedge pclk);
         {rx_mux_clock, rx_sys_clock} <= '0;
         repeat (2) @(posedge pclk);
      end
   endtask : pulse
   function automatic int find(input logic [63:0] s,
                               input logic [31:0] p, input int w);
      for (int i = 0; i + w <= 64; i++)
         if (((s >> i) & ((64'h1 << w) - 1)) === 64'(p)) return i;
      return -1;
   endfunction : find
   task automatic rst;
      presetn <= 0;
      repeat (6) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
   endtask : rst
   // empty every sink so old bits never satisfy a search
   task automatic sclr;
      clr <= 1;
      @(posedge pclk);
      clr <= 0;
   endtask : sclr
   // ==========================================
   // scenarios
   task automatic t_regs;
      apb(0, RXSDO_GLOBAL_ADDR, 0);
      chk("global", GLOBAL_RST, q);
      apb(0, RXSDO_DRVDIS_ADDR + 12'h01C, 0);
      chk("drvdis8", 32'(DRVDIS_RST), q);
      apb(0, RXSDO_SIGPOS_ADDR, 0);
      chk("sigpos", 32'(SIG_MASK), q);
      apb(1, 12'h200, 32'hFFFF_FFFF);
      apb(0, 12'h200, 0);
      chk("unmapped", 32'h0, q);
   endtask : t_regs
   task automatic t_drv;
      apb(1, RXSDO_DRVDIS_ADDR + 12'h008, 32'h10);
      repeat (2) @(posedge pclk);
      chk("oe link3", 8'hFB, line_out_oe);
      chk("neg copy", 8'h5A, line_out_negative);
      chk("pos copy", 8'hA5, line_out_positive);
      apb(0, RXSDO_STATUS_ADDR, 0);
      chk("status oe", 8'hFB, q[7:0]);
      global_driver_disable_in <= 1;
      repeat (2) @(posedge pclk);
      chk("oe global", 8'h00, line_out_oe);
      global_driver_disable_in <= 0;
      apb(1, RXSDO_DRVDIS_ADDR + 12'h008, 0);
      repeat (2) @(posedge pclk);
      chk("oe all", 8'hFF, line_out_oe);
   endtask : t_drv
   task automatic t_master;
      int p;
      apb(1, RXSDO_GLOBAL_ADDR, 32'(RXSDO_MASTER));
      si = 0;
      sc = 0;
      put(0, 16'hA505);
      put(0, 16'h3C0A);
      chk("buf full", 1'b0, byte_ready[0]);
      sclr;
      pulse(9'h001, 40);
      chk("buf empty", 1'b1, byte_ready[0]);
      p = find(sd, 16'hA53C, 16);
      chk("ser found", 1, p >= 0);
      chk("sig align", p, find(ss, 16'h050A, 16));
   endtask : t_master
   task automatic t_slave;
      apb(1, RXSDO_GLOBAL_ADDR, 32'h11);
      si = 1;
      put(1, 16'hC30F);
      sclr;
      pulse(9'h001, 24);
      chk("link1 clk", 1, find(sd, 8'hC3, 8) >= 0);
      apb(1, RXSDO_GLOBAL_ADDR, 32'h01);
      put(1, 16'h9600);
      sclr;
      pulse(9'h001, 24);
      chk("own idle", 1, sd === 64'h0);
      sc = 1;
      sclr;
      pulse(9'h002, 24);
      chk("own clk", 1, find(sd, 8'h96, 8) >= 0);
   endtask : t_slave
   task automatic t_mux;
      rst;
      apb(1, RXSDO_GLOBAL_ADDR, 32'(RXSDO_MUX));
      for (int i = 0; i < LINKS; i++) put(i, {8'(8'h11 * (i + 1)), 8'h0F});
      pulse(9'h0FF, 8);
      sclr;
      pulse(9'h100, 48);
      chk("mux a", 1, find(m0, 32'h11223344, 32) >= 0);
      chk("mux b", 1, find(m1, 32'h55667788, 32) >= 0);
      chk("mux sig", 1, find(u0, 32'h0F0F0F0F, 32) >= 0);
      chk("mux sig b", 1, find(u1, 32'h0F0F0F0F, 32) >= 0);
      chk("backup b", 1, find(b1, 32'h55667788, 32) >= 0);
      chk("backup sig", 1, find(v1, 32'h0F0F0F0F, 32) >= 0);
   endtask : t_mux
   task automatic print_verdict;
      $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : print_verdict
   // ==========================================
   // main sequence and watchdog
   initial begin
      {presetn, psel, penable, pwrite, rx_mux_clock, clr} = '0;
      {paddr, pwdata, byte_valid, byte_in, rx_sys_clock} = '0;
      {global_driver_disable_in, si, sc} = '0;
      line_out_positive_in = 8'hA5;
      line_out_negative_in = 8'h5A;
      rst;
      t_regs;
      t_drv;
      t_master;
      t_slave;
      t_mux;
      print_verdict;
   end
   initial begin
      #3_000_000;
      n_mismatch++;
      print_verdict;
   end
endmodule : rxsdo_bench
`default_nettype wire
